// ===== core/rsmd_defs.svh
// Purpose: Bit positions and codes for the multidrop receive and direction block.
// Assumes: Control registers arrive as plain 8-bit ports.
// Notes: Definitions only.
`ifndef RSMD_DEFS_SVH
`define RSMD_DEFS_SVH

// Extra features control fields.
`define RSMD_EXTRA_FEATURES_CTRL_MD_BIT 0
`define RSMD_EXTRA_FEATURES_CTRL_AUTO_DIR_BIT 4
`define RSMD_EXTRA_FEATURES_CTRL_DIR_INV_BIT 5
// Enhanced feature register: special character detect.
`define RSMD_EFR_SCD_BIT 5
// Modem control: request-to-send bit.
`define RSMD_MCR_RTS_BIT 1
// Interrupt enable: line status interrupt.
`define RSMD_IER_LSI_BIT 2
// Line status: parity error position.
`define RSMD_LSR_PERR_BIT 2
// Line control parity field and the forced-zero code.
`define RSMD_LCR_PAR_HI 5
`define RSMD_LCR_PAR_LO 3
`define RSMD_LCR_FORCE0 3'h7
// Receive enable reset value.
`define RSMD_RX_EN_RST 1'h0
// Two-entry buffer sizing.
`define RSMD_BUF_DEPTH 2'h2

`endif

// ===== core/rsmd_pkg.sv
// Purpose: Types shared by the multidrop receive and direction block.
// Assumes: Constants live in rsmd_defs.svh.
// Notes: One packed state struct per module.
package rsmd_pkg;

	// Character from the receiver: nine bits plus the receiver's own parity check.
	typedef struct packed {
		logic par_bit;
		logic par_err;
		logic [7:0] data;
	} rsmd_rx_char_t;

	// Word stored in the receive path.
	typedef struct packed {
		logic par_err;
		logic [7:0] data;
	} rsmd_fifo_word_t;

	typedef enum logic [1:0] {
		RSMD_PLAIN = 2'b00,
		RSMD_MD_NORMAL = 2'b01,
		RSMD_MD_AUTO = 2'b10
	} rsmd_mode_t;

	typedef struct packed {
		rsmd_fifo_word_t [1:0] mem;
		logic wr_ptr;
		logic rd_ptr;
		logic [1:0] cnt;
	} rsmd_buf_state_t;

	typedef struct packed {
		logic tx_pending;
		logic rts_n;
	} rsmd_dir_state_t;

	typedef struct packed {
		logic rx_en;
		logic perr_flag;
		logic lsi_irq;
	} rsmd_rx_state_t;

endpackage

// ===== core/rsmd_rx_buf.sv
// Purpose: Two-entry buffer between the character filter and the receive FIFO.
// Assumes: Both sides on clk_sys.
// Notes: Read data come from the entry registers.
`timescale 1ns/1ps
`include "rsmd_defs.svh"

module rsmd_rx_buf (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Filling side.
	input wire logic in_valid,
	output logic in_ready,
	input rsmd_pkg::rsmd_fifo_word_t in_word,
	// Draining side.
	output logic out_valid,
	input wire logic out_ready,
	output rsmd_pkg::rsmd_fifo_word_t out_word
);
	import rsmd_pkg::*;

	rsmd_buf_state_t st_ff;
	rsmd_buf_state_t nxt_st;
	logic push;
	logic pop;

	assign in_ready = (st_ff.cnt != `RSMD_BUF_DEPTH);
	assign out_valid = (st_ff.cnt != 2'h0);
	assign out_word = st_ff.mem[st_ff.rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb
	begin
		nxt_st = st_ff;
		if (push)
		begin
			nxt_st.mem[st_ff.wr_ptr] = in_word;
			nxt_st.wr_ptr = ~st_ff.wr_ptr;
		end
		if (pop)
		begin
			nxt_st.rd_ptr = ~st_ff.rd_ptr;
		end
		case ({push, pop})
			2'b10: nxt_st.cnt = st_ff.cnt + 2'h1;
			2'b01: nxt_st.cnt = st_ff.cnt - 2'h1;
			default: nxt_st.cnt = st_ff.cnt;
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st_ff <= '0;
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

endmodule

// ===== core/rsmd_dir_ctrl.sv
// Purpose: Request-to-send output selection with automatic RS-485 direction control.
// Assumes: Transmitter status is on clk_sys.
// Notes: Output is registered, one cycle behind its cause.
`timescale 1ns/1ps
`include "rsmd_defs.svh"

module rsmd_dir_ctrl (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Configuration.
	input wire logic auto_dir,
	input wire logic dir_inv,
	input wire logic mcr_rts,
	input wire logic hw_flow_en,
	input wire logic flow_rts_n,
	// Transmitter status.
	input wire logic tx_fifo_wr,
	input wire logic tx_all_sent,
	// Pin and status.
	output logic rts_n,
	output logic tx_pending
);
	import rsmd_pkg::*;

	rsmd_dir_state_t st_ff;
	rsmd_dir_state_t nxt_st;

	assign rts_n = st_ff.rts_n;
	assign tx_pending = st_ff.tx_pending;

	always_comb
	begin
		nxt_st = st_ff;
		// A write in the same cycle as the last bit leaving keeps the driver on.
		nxt_st.tx_pending = tx_fifo_wr || (st_ff.tx_pending && !tx_all_sent);
		if (auto_dir)
		begin
			nxt_st.rts_n = nxt_st.tx_pending ^ ~dir_inv;
		end
		else if (hw_flow_en)
		begin
			nxt_st.rts_n = flow_rts_n;
		end
		else
		begin
			nxt_st.rts_n = ~mcr_rts;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st_ff <= '{tx_pending: 1'b0, rts_n: 1'b1};
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	a_rts_low_write: assert property ((auto_dir && !dir_inv && tx_fifo_wr) |=> !rts_n)
		else $error("rts not driven low after transmit write");
	a_rts_inv_write: assert property ((auto_dir && dir_inv && tx_fifo_wr) |=> rts_n)
		else $error("inverted rts not driven high after transmit write");
	a_rts_release: assert property (auto_dir && tx_pending && tx_all_sent
		&& !tx_fifo_wr |=> (rts_n == !$past(dir_inv)))
		else $error("rts not released to idle level after last bit");

endmodule

// ===== core/rsmd_rx_ctrl.sv
// Purpose: RS-485 multidrop receive filtering, address detection and driver direction.
// Assumes: Characters and transmitter status come from logic on clk_sys.
// Notes: Control registers are plain ports; line status interrupt is a one-cycle pulse.
`timescale 1ns/1ps
`include "rsmd_defs.svh"

module rsmd_rx_ctrl (
	// Clock and resets.
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic sw_reset,
	// Control registers.
	input wire logic [7:0] extra_features_ctrl,
	input wire logic [7:0] enhanced_feature_reg,
	input wire logic [7:0] line_ctrl_reg,
	input wire logic [7:0] modem_ctrl_reg,
	input wire logic [7:0] irq_enable_reg,
	input wire logic [7:0] second_stop_char_reg,
	input wire logic hw_flow_en,
	input wire logic sw_flow_en,
	input wire logic flow_rts_n,
	// Receive enable access.
	input wire logic rx_en_wr,
	input wire logic rx_en_wdata,
	output logic rx_en,
	// Transmitter status.
	input wire logic tx_fifo_wr,
	input wire logic tx_all_sent,
	output logic rts_n,
	// Characters from the receiver.
	input wire logic rx_char_valid,
	output logic rx_char_ready,
	input rsmd_pkg::rsmd_rx_char_t rx_char,
	// Words to the receive FIFO.
	output logic fifo_valid,
	input wire logic fifo_ready,
	output rsmd_pkg::rsmd_fifo_word_t fifo_word,
	// Line status.
	input wire logic lsr_rd,
	output logic lsr_perr,
	output logic line_status_irq,
	output logic cfg_mismatch
);
	import rsmd_pkg::*;

	// ****************************************************************
	// Mode selection
	// ****************************************************************
	rsmd_rx_state_t st_ff;
	rsmd_rx_state_t nxt_st;
	rsmd_mode_t mode;
	rsmd_fifo_word_t push_word;
	logic push_vld;
	logic push_rdy;
	logic accept;
	logic is_addr;
	logic addr_match;
	logic hw_enable;
	logic hw_disable;
	logic lsi_event;

	always_comb
	begin
		if (!extra_features_ctrl[`RSMD_EXTRA_FEATURES_CTRL_MD_BIT])
		begin
			mode = RSMD_PLAIN;
		end
		else if (enhanced_feature_reg[`RSMD_EFR_SCD_BIT])
		begin
			mode = RSMD_MD_AUTO;
		end
		else
		begin
			mode = RSMD_MD_NORMAL;
		end
	end

	// Flags a multidrop setup that software has left inconsistent; status only.
	assign cfg_mismatch = extra_features_ctrl[`RSMD_EXTRA_FEATURES_CTRL_MD_BIT] && (hw_flow_en || sw_flow_en
		|| (mode == RSMD_MD_NORMAL
		&& line_ctrl_reg[`RSMD_LCR_PAR_HI:`RSMD_LCR_PAR_LO] != `RSMD_LCR_FORCE0));

	// ****************************************************************
	// Character filter
	// ****************************************************************
	// A dropped character still waits for buffer room, which keeps the
	// handshake simple at the cost of a stall during a full buffer.
	assign accept = rx_char_valid && push_rdy;
	assign rx_char_ready = push_rdy;
	assign is_addr = rx_char.par_bit;
	assign addr_match = (rx_char.data == second_stop_char_reg);

	always_comb
	begin
		push_vld = 1'b0;
		push_word.data = rx_char.data;
		push_word.par_err = rx_char.par_err;
		hw_enable = 1'b0;
		hw_disable = 1'b0;
		lsi_event = 1'b0;
		case (mode)
			RSMD_PLAIN:
			begin
				push_vld = rx_char_valid;
				lsi_event = rx_char.par_err;
			end
			RSMD_MD_NORMAL:
			begin
				if (is_addr)
				begin
					// Address bytes are always kept, whether enabled or not.
					push_vld = rx_char_valid;
					push_word.par_err = 1'b1;
					lsi_event = 1'b1;
				end
				else
				begin
					push_vld = rx_char_valid && st_ff.rx_en;
				end
			end
			RSMD_MD_AUTO:
			begin
				if (is_addr && addr_match)
				begin
					push_vld = rx_char_valid;
					push_word.par_err = rx_char.par_bit;
					hw_enable = 1'b1;
					lsi_event = 1'b1;
				end
				else if (is_addr)
				begin
					hw_disable = 1'b1;
				end
				else
				begin
					push_vld = rx_char_valid && st_ff.rx_en;
				end
			end
			default:
			begin
				push_vld = 1'b0;
			end
		endcase
	end

	// ****************************************************************
	// State update
	// ****************************************************************
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.lsi_irq = accept && lsi_event && irq_enable_reg[`RSMD_IER_LSI_BIT];
		if (sw_reset)
		begin
			nxt_st.rx_en = `RSMD_RX_EN_RST;
			nxt_st.perr_flag = 1'b0;
		end
		else
		begin
			// Hardware enable beats a software clear in the same cycle.
			if (accept && hw_enable)
			begin
				nxt_st.rx_en = 1'b1;
			end
			else if (accept && hw_disable)
			begin
				nxt_st.rx_en = 1'b0;
			end
			else if (rx_en_wr)
			begin
				nxt_st.rx_en = rx_en_wdata;
			end
			// A stored error in the read cycle is kept for the next read.
			if (accept && push_vld && push_word.par_err)
			begin
				nxt_st.perr_flag = 1'b1;
			end
			else if (lsr_rd)
			begin
				nxt_st.perr_flag = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			st_ff <= '{rx_en: `RSMD_RX_EN_RST, perr_flag: 1'b0, lsi_irq: 1'b0};
		end
		else
		begin
			st_ff <= nxt_st;
		end
	end

	assign rx_en = st_ff.rx_en;
	assign lsr_perr = st_ff.perr_flag;
	assign line_status_irq = st_ff.lsi_irq;

	// ****************************************************************
	// Buffer and direction control
	// ****************************************************************
	rsmd_rx_buf u_buf (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(push_vld),
		.in_ready(push_rdy),
		.in_word(push_word),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready),
		.out_word(fifo_word)
	);

	// Flow control must be off in auto direction mode; the direction logic wins anyway.
	rsmd_dir_ctrl u_dir (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.auto_dir(extra_features_ctrl[`RSMD_EXTRA_FEATURES_CTRL_AUTO_DIR_BIT]),
		.dir_inv(extra_features_ctrl[`RSMD_EXTRA_FEATURES_CTRL_DIR_INV_BIT]),
		.mcr_rts(modem_ctrl_reg[`RSMD_MCR_RTS_BIT]),
		.hw_flow_en(hw_flow_en),
		.flow_rts_n(flow_rts_n),
		.tx_fifo_wr(tx_fifo_wr),
		.tx_all_sent(tx_all_sent),
		.rts_n(rts_n),
		.tx_pending()
	);

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_norm_addr;
		accept && (mode == RSMD_MD_NORMAL) && rx_char.par_bit;
	endsequence

	sequence s_auto_match;
		accept && (mode == RSMD_MD_AUTO) && rx_char.par_bit && addr_match && !sw_reset;
	endsequence

	sequence s_auto_miss;
		accept && (mode == RSMD_MD_AUTO) && rx_char.par_bit && !addr_match
			&& !sw_reset && st_ff.rx_en;
	endsequence

	a_md_enable_bit: assert property ((accept && !extra_features_ctrl[0]) |-> push_vld)
		else $error("plain mode dropped a character");
	a_drop_data_off: assert property ((accept && (mode == RSMD_MD_NORMAL)
		&& !rx_char.par_bit && !st_ff.rx_en) |-> !push_vld)
		else $error("data byte kept while receiver disabled");
	a_addr_irq: assert property (s_norm_addr
		|=> (line_status_irq == $past(irq_enable_reg[`RSMD_IER_LSI_BIT])))
		else $error("address byte line status interrupt wrong");
	a_addr_perr_flag: assert property ((s_norm_addr and !sw_reset) |=> lsr_perr)
		else $error("address byte did not set parity error");
	a_addr_stored: assert property (s_norm_addr |=> fifo_valid)
		else $error("address byte not stored");
	a_data_kept_on: assert property ((accept && (mode != RSMD_MD_AUTO) && !rx_char.par_bit
		&& st_ff.rx_en) |-> (push_vld && push_word.data == rx_char.data))
		else $error("data byte dropped while receiver enabled");
	a_auto_drop_off: assert property ((accept && (mode == RSMD_MD_AUTO) && !st_ff.rx_en
		&& !(rx_char.par_bit && addr_match)) |-> !push_vld)
		else $error("auto mode kept a byte while disabled");
	a_auto_match_en: assert property (s_auto_match |=> (rx_en && fifo_valid))
		else $error("matching address did not enable and store");
	a_auto_miss_dis: assert property (s_auto_miss |-> !push_vld ##1 !rx_en)
		else $error("non-matching address did not disable receiver");
	a_auto_match_bit: assert property (s_auto_match
		|-> (push_vld && push_word.par_err && push_word.data == rx_char.data))
		else $error("matching address stored without its ninth bit");
	a_sw_reset_en: assert property (sw_reset |=> (!rx_en && !lsr_perr))
		else $error("software reset left receiver enabled");
	a_irq_pulse: assert property (line_status_irq |-> $past(accept))
		else $error("line status interrupt without a character");
	// Plain mode passes the receiver's own parity error on to the interrupt.
	a_plain_irq: assert property (accept && (mode == RSMD_PLAIN) && rx_char.par_err
		|=> (line_status_irq == $past(irq_enable_reg[`RSMD_IER_LSI_BIT])))
		else $error("plain mode parity error interrupt wrong");
	a_perr_sticky: assert property (lsr_perr && !lsr_rd && !sw_reset |=> lsr_perr)
		else $error("parity error status lost before it was read");
	a_en_sw_write: assert property (rx_en_wr && !sw_reset && !accept
		|=> (rx_en == $past(rx_en_wdata)))
		else $error("receive enable write not taken");

endmodule

// ===== core/rsmd_rx_ctrl_end.sv
`timescale 1ns/1ps

// ===== verif/rsmd_station_model.sv
// Purpose: Line-side station that hands received characters to the block.
// Assumes: One character is offered at a time and held until it is taken.
// Notes: Between characters the data lines toggle, so a stale value never matches.
`timescale 1ns/1ps

module rsmd_station_model (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Character handshake.
	output logic rx_char_valid,
	input wire logic rx_char_ready,
	output rsmd_pkg::rsmd_rx_char_t rx_char,
	// Status.
	output logic hung
);
	import rsmd_pkg::*;

	rsmd_rx_char_t held = '0;
	rsmd_rx_char_t idle_pat = '0;

	initial
	begin
		rx_char_valid = 1'b0;
		hung = 1'b0;
	end

	always @(posedge clk_sys) idle_pat <= ~idle_pat;
	assign rx_char = rx_char_valid ? held : idle_pat;

	// The ninth bit that the caller passes marks an address character.
	task send(input rsmd_rx_char_t c);
		int i;
		@(posedge clk_sys);
		held <= c;
		rx_char_valid <= 1'b1;
		for (i = 0; i < 100; i++)
		begin
			@(posedge clk_sys);
			if (rx_char_ready === 1'b1) break;
		end
		if (i == 100) hung <= 1'b1;
		rx_char_valid <= 1'b0;
	endtask
endmodule

// ===== verif/rsmd_rx_ctrl_test.sv
// Purpose: Self-checking bench for multidrop filtering and direction control.
// Assumes: Software keeps flow control off outside the direction cases and forces parity zero.
// Notes: Expected words are queued by the driver and popped by the monitor.
`timescale 1ns/1ps

module rsmd_rx_ctrl_test;
	import rsmd_pkg::*;

	localparam logic [7:0] MY_ID = 8'h5a;
	logic clk_sys = 1'b0, rst_n = 1'b0, sw_reset = 1'b0, stall = 1'b0;
	logic [7:0] extra_features_ctrl = 8'h00, enhanced_feature_reg = 8'h00;
	logic [7:0] line_ctrl_reg = 8'h38;
	logic [7:0] modem_ctrl_reg = 8'h00, irq_enable_reg = 8'h00;
	logic [7:0] second_stop_char_reg = MY_ID;
	logic hw_flow_en = 1'b0, sw_flow_en = 1'b0, flow_rts_n = 1'b1;
	logic rx_en_wr = 1'b0, rx_en_wdata = 1'b0, tx_fifo_wr = 1'b0, tx_all_sent = 1'b1;
	logic fifo_ready = 1'b0, lsr_rd = 1'b0;
	logic rx_en, rts_n, rx_char_valid, rx_char_ready, fifo_valid, lsr_perr;
	logic line_status_irq, cfg_mismatch, hung, exp_en = 1'b0, exp_perr = 1'b0, a;
	logic [7:0] d;
	rsmd_rx_char_t rx_char;
	rsmd_fifo_word_t fifo_word, w;
	rsmd_fifo_word_t exp_q[$];
	int num_errors = 0, n_checks = 0, irq_cnt = 0, exp_irq = 0, n;
	integer seed = 32'h23dea876;

	rsmd_rx_ctrl dut (.clk_sys, .rst_n, .sw_reset, .extra_features_ctrl,
		.enhanced_feature_reg, .line_ctrl_reg, .modem_ctrl_reg, .irq_enable_reg,
		.second_stop_char_reg, .hw_flow_en, .sw_flow_en, .flow_rts_n, .rx_en_wr,
		.rx_en_wdata, .rx_en, .tx_fifo_wr, .tx_all_sent, .rts_n, .rx_char_valid,
		.rx_char_ready, .rx_char, .fifo_valid, .fifo_ready, .fifo_word, .lsr_rd,
		.lsr_perr, .line_status_irq, .cfg_mismatch);
	rsmd_station_model u_sta (.clk_sys, .rst_n, .rx_char_valid, .rx_char_ready,
		.rx_char, .hung);

	// ****************************************
	// Clock, monitor and checking.
	// ****************************************
	always #12.5 clk_sys = ~clk_sys;
	always @(posedge clk_sys) fifo_ready <= !stall && ($random(seed) & 1);
	always @(posedge clk_sys) if (line_status_irq === 1'b1) irq_cnt++;
	always @(posedge clk_sys)
	begin
		if (hung === 1'b1)
		begin
			num_errors++;
			end_sim;
		end
		if (rst_n && fifo_valid === 1'b1 && fifo_ready === 1'b1)
		begin
			if (exp_q.size() == 0) check("extra_word", 10'h1, 10'h0);
			else
			begin
				w = exp_q.pop_front();
				check("fifo_word", 10'(fifo_word), 10'(w));
			end
		end
	end

	task check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task end_sim;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task tk(input int k);
		repeat (k) @(posedge clk_sys);
		#1;
	endtask

	// ****************************************
	// Drivers.
	// ****************************************
	task cfg(input logic [7:0] ef, input logic scd);
		@(posedge clk_sys);
		extra_features_ctrl <= ef;
		enhanced_feature_reg <= {2'b00, scd, 5'b00000};
		irq_enable_reg <= 8'($random(seed));
		tk(1);
	endtask

	// The reference decides keep, flag and enable before the character is offered.
	task send_char(input logic par, input logic [7:0] dat);
		logic k, pe;
		k = 1'b1;
		pe = par;
		if (extra_features_ctrl[0] && !enhanced_feature_reg[5])
		begin
			k = par | exp_en;
			pe = par;
		end
		else if (extra_features_ctrl[0])
		begin
			k = par ? dat == second_stop_char_reg : exp_en;
			pe = par;
			if (par) exp_en = dat == second_stop_char_reg;
		end
		if (k) exp_q.push_back('{par_err: pe, data: dat});
		if (k && pe)
		begin
			exp_perr = 1'b1;
			exp_irq += irq_enable_reg[2];
		end
		u_sta.send('{par_bit: par, par_err: par, data: dat});
	endtask

	task set_en(input logic v);
		@(posedge clk_sys);
		rx_en_wr <= 1'b1;
		rx_en_wdata <= v;
		@(posedge clk_sys);
		rx_en_wr <= 1'b0;
		exp_en = v;
	endtask

	task settle;
		int i;
		for (i = 0; i < 300 && (exp_q.size() > 0 || fifo_valid !== 1'b0); i++)
			@(posedge clk_sys);
		if (i == 300)
		begin
			check("drain", 10'h1, 10'h0);
			end_sim;
		end
		tk(3);
		check("rx_en", 10'(rx_en), 10'(exp_en));
		check("lsr_perr", 10'(lsr_perr), 10'(exp_perr));
		check("irq_count", 10'(irq_cnt), 10'(exp_irq));
		check("cfg_mismatch", 10'(cfg_mismatch), 10'h0);
		@(posedge clk_sys);
		lsr_rd <= 1'b1;
		@(posedge clk_sys);
		lsr_rd <= 1'b0;
		exp_perr = 1'b0;
		tk(1);
		check("lsr_clear", 10'(lsr_perr), 10'h0);
	endtask

	task random_run(input int cnt, input logic own);
		for (n = 0; n < cnt; n++)
		begin
			a = 1'($random(seed));
			d = ($random(seed) & 1) ? MY_ID : 8'($random(seed));
			send_char(a, d);
			if (own && a) set_en(d == MY_ID);
		end
		settle;
	endtask

	task dir_case(input logic au, input logic inv, input logic hw);
		logic idle;
		@(posedge clk_sys);
		extra_features_ctrl <= {2'b00, inv, au, 4'h0};
		hw_flow_en <= hw && !au;
		flow_rts_n <= 1'($random(seed));
		modem_ctrl_reg <= 8'($random(seed));
		tk(3);
		idle = au ? !inv : (hw_flow_en ? flow_rts_n : !modem_ctrl_reg[1]);
		check("rts_idle", 10'(rts_n), 10'(idle));
		@(posedge clk_sys);
		tx_fifo_wr <= 1'b1;
		tx_all_sent <= 1'b0;
		@(posedge clk_sys);
		tx_fifo_wr <= 1'b0;
		tk(3);
		check("rts_busy", 10'(rts_n), 10'(au ? inv : idle));
		@(posedge clk_sys);
		tx_all_sent <= 1'b1;
		tk(3);
		check("rts_done", 10'(rts_n), 10'(idle));
	endtask

	initial
	begin
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		tk(1);
		check("rst_rts", 10'(rts_n), 10'h1);
		check("rst_rx_en", 10'(rx_en), 10'h0);
		check("rst_valid", 10'(fifo_valid), 10'h0);
		cfg(8'h00, 1'b0);
		random_run(6, 1'b0);
		cfg(8'h01, 1'b0);
		random_run(30, 1'b1);
		cfg(8'h01, 1'b1);
		random_run(30, 1'b0);
		// A normal multidrop setup without forced parity zero must be flagged.
		cfg(8'h01, 1'b0);
		@(posedge clk_sys);
		line_ctrl_reg <= 8'h00;
		tk(1);
		check("cfg_mismatch", 10'(cfg_mismatch), 10'h1);
		@(posedge clk_sys);
		line_ctrl_reg <= 8'h38;
		// A stalled reader fills both entries and must then refuse more characters.
		cfg(8'h00, 1'b0);
		stall = 1'b1;
		tk(2);
		send_char(1'b0, 8'h11);
		send_char(1'b0, 8'h22);
		tk(1);
		check("full_ready", 10'(rx_char_ready), 10'h0);
		stall = 1'b0;
		settle;
		set_en(1'b1);
		tk(2);
		check("en_write", 10'(rx_en), 10'h1);
		@(posedge clk_sys);
		sw_reset <= 1'b1;
		@(posedge clk_sys);
		sw_reset <= 1'b0;
		exp_en = 1'b0;
		tk(1);
		check("sw_reset", 10'(rx_en), 10'h0);
		for (n = 0; n < 8; n++) dir_case(n[0], n[1], n[2]);
		end_sim;
	end
endmodule
